// ===== design/triple_timer_pin_logic.sv
// triple timer with axi4-lite register file, interrupt and timer pins
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "timer_cfg.svh"
module triple_timer_pin_logic
   import timer_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [`ADDR_W-1:0] awaddr,
   // axi4-lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [`DATA_W-1:0] wdata,
   input wire logic [`NLANES-1:0] wstrb,
   // axi4-lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [`ADDR_W-1:0] araddr,
   // axi4-lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [`DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   // processing state of the core
   input wire logic stop_req,
   input wire logic wait_req,
   // timer pins
   input wire logic timer_pin_0_i,
   output logic timer_pin_0_o,
   output logic timer_pin_0_oe_n,
   input wire logic timer_pin_1_i,
   output logic timer_pin_1_o,
   output logic timer_pin_1_oe_n,
   input wire logic timer_pin_2_i,
   output logic timer_pin_2_o,
   output logic timer_pin_2_oe_n,
   // interrupt
   output logic irq
);

   // address check shared by the read and write paths
   function automatic logic addr_ok(input logic [`ADDR_W-1:0] a);
      logic [`ADDR_W-1:0] al;
      al = {a[`ADDR_W-1:`REG_IDX_LO], `LOW_ZERO};
      addr_ok = (al[`TOP_HI:`TOP_LO] == 2'h0 && al[`TMR_IDX_HI:`TMR_IDX_LO] <= `TMR_LAST &&
                 al[`REG_IDX_HI:`REG_IDX_LO] <= `REG_CNT) || al == `OFF_STAT || al == `OFF_MASK;
   endfunction : addr_ok

   // byte-lane merge of a write onto the current register word
   function automatic logic [`DATA_W-1:0] merge(input logic [`DATA_W-1:0] old,
                                                input logic [`DATA_W-1:0] nw,
                                                input logic [`NLANES-1:0] strb);
      merge = old;
      for (int b = 0; b < `NLANES; b++)
      begin
         if (strb[b])
         begin
            merge[b*`LANE_W +: `LANE_W] = nw[b*`LANE_W +: `LANE_W];
         end
      end
   endfunction : merge

   logic aw_have_r;
   logic [`ADDR_W-1:0] aw_addr_r;
   logic w_have_r;
   logic [`DATA_W-1:0] w_data_r;
   logic [`NLANES-1:0] w_strb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [`DATA_W-1:0] rdata_r;
   logic [1:0] rresp_r;
   tmr_cfg_s ctrl_r [`NTMR];
   tmr_cfg_s ctrl_nxt [`NTMR];
   count_t cmp_r [`NTMR];
   count_t cmp_nxt [`NTMR];
   logic [`NTMR-1:0] stat_r;
   logic [`NTMR-1:0] stat_nxt;
   logic [`NTMR-1:0] mask_r;
   logic [`NTMR-1:0] mask_nxt;
   logic [`DATA_W-1:0] ctrl_word [`NTMR];
   count_t cnt_view [`NTMR];
   count_t tmr_count [`NTMR];
   count_t tmr_capture [`NTMR];
   logic [`NTMR-1:0] tmr_done;
   logic [`NTMR-1:0] pin_in;
   logic [`NTMR-1:0] pin_o_w;
   logic [`NTMR-1:0] pin_oe_n_w;
   logic [`DATA_W-1:0] rd_word;
   logic [`DATA_W-1:0] mask_merged;

   // write channel: address and data are taken in either order, one write at a time
   assign awready = ~aw_have_r & ~bvalid_r;
   assign wready = ~w_have_r & ~bvalid_r;
   wire wr_fire = aw_have_r & w_have_r & ~bvalid_r;
   wire wr_ok = addr_ok(aw_addr_r);
   wire [1:0] wr_t = aw_addr_r[`TMR_IDX_HI:`TMR_IDX_LO];
   wire [1:0] wr_reg = aw_addr_r[`REG_IDX_HI:`REG_IDX_LO];
   wire [`ADDR_W-1:0] wr_al = {aw_addr_r[`ADDR_W-1:`REG_IDX_LO], `LOW_ZERO};
   wire wr_tmr = wr_fire & wr_ok & (aw_addr_r[`TOP_HI:`TOP_LO] == 2'h0) & (wr_t <= `TMR_LAST);
   wire wr_stat = wr_fire & (wr_al == `OFF_STAT);
   wire wr_mask = wr_fire & (wr_al == `OFF_MASK);
   assign mask_merged = merge(32'(mask_r), w_data_r, w_strb_r);

   // read channel decode
   assign arready = ~rvalid_r;
   wire ar_fire = arvalid & arready;
   wire [1:0] rd_t = araddr[`TMR_IDX_HI:`TMR_IDX_LO];
   wire [1:0] rd_reg = araddr[`REG_IDX_HI:`REG_IDX_LO];
   wire [`ADDR_W-1:0] rd_al = {araddr[`ADDR_W-1:`REG_IDX_LO], `LOW_ZERO};
   assign rd_word = !addr_ok(araddr) ? `ZERO32 :
                    (rd_al == `OFF_STAT) ? 32'(stat_r) :
                    (rd_al == `OFF_MASK) ? 32'(mask_r) :
                    (rd_reg == `REG_CTRL) ? ctrl_word[rd_t] :
                    (rd_reg == `REG_CMP) ? 32'(cmp_r[rd_t]) : 32'(cnt_view[rd_t]);

   assign pin_in = {timer_pin_2_i, timer_pin_1_i, timer_pin_0_i};

   // per timer: register view, write decode and the channel itself
   for (genvar i = 0; i < `NTMR; i++)
   begin : g_tmr
      wire sel_ctrl = wr_tmr & (wr_t == 2'(i)) & (wr_reg == `REG_CTRL);
      wire sel_cmp = wr_tmr & (wr_t == 2'(i)) & (wr_reg == `REG_CMP);
      wire [`DATA_W-1:0] ctrl_m = merge(ctrl_word[i], w_data_r, w_strb_r);
      wire [`DATA_W-1:0] cmp_m = merge(32'(cmp_r[i]), w_data_r, w_strb_r);
      // an illegal mode code keeps the previous mode
      wire mode_ok = ctrl_m[`B_MODE_HI:`B_MODE_LO] <= MODE_MEASURE;
      wire [2:0] mode_bits = mode_ok ? ctrl_m[`B_MODE_HI:`B_MODE_LO] : ctrl_r[i].mode;
      // a done flag clears on a written one, either through its own word or the status word
      wire clr = (sel_ctrl & w_strb_r[`LANE_DONE] & w_data_r[`B_DONE]) |
                 (wr_stat & w_strb_r[`LANE_FLAGS] & w_data_r[i]);

      assign ctrl_word[i] = 32'({pin_in[i], stat_r[i], mask_r[i], ctrl_r[i]});
      assign ctrl_nxt[i] = sel_ctrl ? tmr_cfg_s'({ctrl_m[`B_FUNC:`B_EXT], mode_bits, ctrl_m[`B_EN]}) : ctrl_r[i];
      assign cmp_nxt[i] = sel_cmp ? cmp_m[`CNT_W-1:0] : cmp_r[i];
      // set wins over a clear arriving in the same cycle
      assign stat_nxt[i] = tmr_done[i] | (stat_r[i] & ~clr);
      assign mask_nxt[i] = wr_mask ? mask_merged[i] : (sel_ctrl ? ctrl_m[`B_IE] : mask_r[i]);
      assign cnt_view[i] = (ctrl_r[i].mode == MODE_MEASURE) ? tmr_capture[i] : tmr_count[i];

      timer_unit u_tmr
      (
         .aclk(aclk),
         .aresetn(aresetn),
         .cfg(ctrl_r[i]),
         .compare(cmp_r[i]),
         .stop_req(stop_req),
         .pin_i(pin_in[i]),
         .pin_o(pin_o_w[i]),
         .pin_oe_n(pin_oe_n_w[i]),
         .done_evt(tmr_done[i]),
         .count(tmr_count[i]),
         .capture(tmr_capture[i])
      );
   end

   // register file; reset leaves every pin a gpio input
   always_ff @(posedge aclk)
   begin
      for (int k = 0; k < `NTMR; k++)
      begin
         ctrl_r[k] <= aresetn ? ctrl_nxt[k] : tmr_cfg_s'(`CTRL_RST);
         cmp_r[k] <= aresetn ? cmp_nxt[k] : `CMP_RST;
      end
      stat_r <= aresetn ? stat_nxt : '0;
      mask_r <= aresetn ? mask_nxt : '0;
   end

   // write address and data holding registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_r <= 1'b0;
         aw_addr_r <= '0;
         w_have_r <= 1'b0;
         w_data_r <= `ZERO32;
         w_strb_r <= '0;
      end
      else
      begin
         aw_have_r <= (awvalid & awready) | (aw_have_r & ~wr_fire);
         aw_addr_r <= (awvalid & awready) ? awaddr : aw_addr_r;
         w_have_r <= (wvalid & wready) | (w_have_r & ~wr_fire);
         w_data_r <= (wvalid & wready) ? wdata : w_data_r;
         w_strb_r <= (wvalid & wready) ? wstrb : w_strb_r;
      end
   end

   // responses; unmapped addresses answer slverr, writes to the count word are ignored
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_r <= 1'b0;
         bresp_r <= `RESP_OKAY;
         rvalid_r <= 1'b0;
         rdata_r <= `ZERO32;
         rresp_r <= `RESP_OKAY;
      end
      else
      begin
         bvalid_r <= wr_fire | (bvalid_r & ~bready);
         bresp_r <= wr_fire ? (wr_ok ? `RESP_OKAY : `RESP_SLVERR) : bresp_r;
         rvalid_r <= ar_fire | (rvalid_r & ~rready);
         rdata_r <= ar_fire ? rd_word : rdata_r;
         rresp_r <= ar_fire ? (addr_ok(araddr) ? `RESP_OKAY : `RESP_SLVERR) : rresp_r;
      end
   end

   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign rvalid = rvalid_r;
   assign rdata = rdata_r;
   assign rresp = rresp_r;

   // interrupt level from unmasked sticky flags
   assign irq = |(stat_r & mask_r);

   // pins; wait_req deliberately feeds nothing so wait cannot disturb them
   assign timer_pin_0_o = pin_o_w[0];
   assign timer_pin_0_oe_n = pin_oe_n_w[0];
   assign timer_pin_1_o = pin_o_w[1];
   assign timer_pin_1_oe_n = pin_oe_n_w[1];
   assign timer_pin_2_o = pin_o_w[2];
   assign timer_pin_2_oe_n = pin_oe_n_w[2];

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   for (genvar j = 0; j < `NTMR; j++)
   begin : g_chk
      wire c_in = (ctrl_r[j].mode == MODE_EVENT) || (ctrl_r[j].mode == MODE_MEASURE);
      pin_dir_in_a: assert property (ctrl_r[j].func && c_in |=> pin_oe_n_w[j])
         else $error("timer pin driven in an input mode");
      pin_dir_out_a: assert property (ctrl_r[j].func && !c_in && !stop_req |=> !pin_oe_n_w[j])
         else $error("timer pin not driven in an output mode");
      gpio_drive_a: assert property (!ctrl_r[j].func && ctrl_r[j].gpio_dir && !stop_req
                                     |=> !pin_oe_n_w[j] && pin_o_w[j] == $past(ctrl_r[j].gpio_out))
         else $error("gpio output not driven with its value");
      stop_hold_a: assert property (stop_req && $past(stop_req) |-> $stable(tmr_count[j]))
         else $error("counter moved during stop");
      flag_set_a: assert property (tmr_done[j] |=> stat_r[j] ##0 ctrl_word[j][`B_DONE])
         else $error("count match did not set the status flag");
   end

   reset_input_a: assert property (@(posedge aclk) disable iff (1'b0)
                                   !aresetn |=> (&pin_oe_n_w) && ctrl_r[0] == tmr_cfg_s'(`CTRL_RST))
      else $error("pins not gpio inputs after reset");
   stop_tristate_a: assert property (stop_req |=> &pin_oe_n_w)
      else $error("pin driven during stop");
   wait_steady_a: assert property ((wait_req != $past(wait_req)) && !stop_req && !$past(stop_req)
                                   && !$past(wr_fire) |=> $stable(pin_oe_n_w))
      else $error("wait changed a pin direction");
   irq_raise_a: assert property (|(tmr_done & mask_r) && !wr_fire |=> irq)
      else $error("enabled flag did not raise the interrupt");
   rsp_bound_a: assert property (wr_fire |=> bvalid ##0 bresp == $past(wr_ok ? `RESP_OKAY : `RESP_SLVERR))
      else $error("write response missing or wrong");

   stop_seen_c: cover property (!stop_req ##1 stop_req [*3] ##1 !stop_req);
   irq_seen_c: cover property ($rose(irq));
   meas_seen_c: cover property (ctrl_r[0].mode == MODE_MEASURE && tmr_done[0]);
   flag_clr_c: cover property (stat_r[1] ##1 !stat_r[1]);

endmodule : triple_timer_pin_logic
`default_nettype wire

// ===== pkg/timer_cfg.svh
// register map, field positions, reset values and widths of the triple timer
// How it works
// - three identical timers run independently, each on internal ticks or external pin edges
// - each timer flags its processor interrupt or drives its pin after a programmed count
// - event counter and measurement modes use the timer pin as an input
// - watchdog, plain timer and pulse modulation modes drive the timer pin as output
// - after reset pins are gpio inputs; control/status writes make them outputs or timer pins
// - in stop a pin keeps its direction; the timer ignores inputs, the control/status pin bit still reads live, outputs are tri-stated
// - wait state changes neither drive nor direction of any timer pin
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

// sizes
`define CNT_W 24
`define NTMR 3
`define TMR_LAST 2'h2
`define ADDR_W 8
`define DATA_W 32
`define NLANES 4
`define LANE_W 8

// address decode: [7:6] zero, [5:4] timer, [3:2] register within timer
`define TOP_HI 7
`define TOP_LO 6
`define TMR_IDX_HI 5
`define TMR_IDX_LO 4
`define REG_IDX_HI 3
`define REG_IDX_LO 2
`define LOW_ZERO 2'h0
`define REG_CTRL 2'h0
`define REG_CMP 2'h1
`define REG_CNT 2'h2
`define OFF_STAT 8'h30
`define OFF_MASK 8'h34

// control/status word fields
`define B_EN 0
`define B_MODE_LO 1
`define B_MODE_HI 3
`define B_EXT 4
`define B_GDIR 5
`define B_GOUT 6
`define B_FUNC 7
`define B_IE 8
`define B_DONE 9
`define B_PIN 10
`define LANE_DONE 1
`define LANE_FLAGS 0

// reset values and answers
`define CTRL_RST 8'h00
`define CMP_RST 24'hff_ffff
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define ZERO32 32'h0000_0000

`endif

// ===== pkg/timer_pkg.sv
// types shared by the triple timer modules
package timer_pkg;
`include "timer_cfg.svh"

   typedef logic [`CNT_W-1:0] count_t;

   typedef enum logic [2:0]
   {
      MODE_TIMER    = 3'b000,
      MODE_WATCHDOG = 3'b001,
      MODE_PWM      = 3'b010,
      MODE_EVENT    = 3'b011,
      MODE_MEASURE  = 3'b100
   } tmr_mode_e;

   // packed so that bit positions match the low byte of the control/status word
   typedef struct packed
   {
      logic func;
      logic gpio_out;
      logic gpio_dir;
      logic ext_clk;
      tmr_mode_e mode;
      logic enable;
   } tmr_cfg_s;

endpackage : timer_pkg

// ===== design/timer_unit.sv
// one timer channel: counter, compare, pin direction and pin drive
`timescale 1ns/1ns
`default_nettype none
`include "timer_cfg.svh"
module timer_unit
   import timer_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // configuration
   input wire tmr_cfg_s cfg,
   input wire count_t compare,
   input wire logic stop_req,
   // timer pin
   input wire logic pin_i,
   output logic pin_o,
   output logic pin_oe_n,
   // status
   output logic done_evt,
   output count_t count,
   output count_t capture
);

   logic pin_q_r;
   logic wave_r;
   logic wave_nxt;
   count_t count_r;
   count_t count_nxt;
   count_t capture_r;
   count_t cnt_inc;

   // mode decode; stop freezes the sampled pin so an input is ignored
   wire in_mode = (cfg.mode == MODE_EVENT) || (cfg.mode == MODE_MEASURE);
   wire measure = cfg.mode == MODE_MEASURE;
   wire pin_live = stop_req ? pin_q_r : pin_i;
   wire pin_rise = pin_live & ~pin_q_r;
   wire pin_fall = ~pin_live & pin_q_r;
   wire run = cfg.enable & ~stop_req;
   wire ext_src = cfg.ext_clk | (cfg.mode == MODE_EVENT);

   // event source: internal tick every cycle, every cycle the pin is high in measure mode, or external pin edge
   wire tick = run & (measure ? pin_live : (ext_src ? pin_rise : 1'b1));
   assign cnt_inc = count_r + 1'b1;
   wire hit = tick & ~measure & (cnt_inc == compare);
   wire meas_end = run & measure & pin_fall;
   // fixed half-period duty keeps the channel free of a duty register
   wire pwm_level = count_r < (compare >> 1);

   // next counter and waveform values
   assign count_nxt = (!cfg.enable || hit || meas_end) ? '0 : (tick ? cnt_inc : count_r);
   assign wave_nxt = !cfg.enable ? 1'b0 :
                     (hit && cfg.mode == MODE_TIMER) ? ~wave_r :
                     (hit && cfg.mode == MODE_WATCHDOG) ? 1'b1 : wave_r;

   // direction: timer function follows the mode, gpio follows its direction bit
   wire drive = cfg.func ? ~in_mode : cfg.gpio_dir;
   wire out_val = cfg.func ? ((cfg.mode == MODE_PWM) ? pwm_level : wave_nxt) : cfg.gpio_out;

   // counter, capture and pin registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_q_r <= 1'b0;
         wave_r <= 1'b0;
         count_r <= '0;
         capture_r <= '0;
         done_evt <= 1'b0;
         pin_o <= 1'b0;
         pin_oe_n <= 1'b1; // gpio input after reset
      end
      else
      begin
         pin_q_r <= pin_live;
         wave_r <= wave_nxt;
         count_r <= count_nxt;
         capture_r <= meas_end ? count_r : capture_r;
         done_evt <= hit | meas_end;
         pin_o <= stop_req ? pin_o : out_val;
         pin_oe_n <= ~(drive & ~stop_req); // tri-state in stop
      end
   end

   assign count = count_r;
   assign capture = capture_r;

   default clocking ucb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   count_hit_a: assert property (hit |=> done_evt && count_r == '0)
      else $error("compare match did not flag and restart the count");
   ext_hold_a: assert property (run && ext_src && !measure && !pin_rise |=> $stable(count_r))
      else $error("external clocked counter moved without a pin edge");
   meas_cap_a: assert property (meas_end |=> capture_r == $past(count_r) && count_r == '0)
      else $error("measurement end did not capture the count");

endmodule : timer_unit
`default_nettype wire

// ===== test/pin_partner.sv
// far-side model of the three timer pins
`timescale 1ns/1ns
`default_nettype none
module pin_partner
(
   // clock
   input wire logic aclk,
   // far-side drive request from the bench
   input wire logic [2:0] drv_en,
   input wire logic [2:0] drv_val,
   // design side of the pins
   input wire logic [2:0] pin_o,
   input wire logic [2:0] pin_oe_n,
   output logic [2:0] pin_i
);
   // an undriven pin has no pull, so it wanders rather than keeping a stale level
   logic [2:0] idle_r = 3'h0;

   always @(posedge aclk)
      idle_r <= ~idle_r;

   // the driving party sets the wire level; input modes rely on the far side driving
   assign pin_i = (~pin_oe_n & pin_o) | (pin_oe_n & drv_en & drv_val) | (pin_oe_n & ~drv_en & idle_r);
endmodule : pin_partner
`default_nettype wire

// ===== test/triple_timer_pin_logic_tb.sv
// self-checking bench for the triple timer pin logic
`timescale 1ns/1ns
`default_nettype none
`include "timer_cfg.svh"
module triple_timer_pin_logic_tb;
   import timer_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, stop_req = 1'b0, wait_req = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [`ADDR_W-1:0] awaddr = 8'h00, araddr = 8'h00;
   logic [`DATA_W-1:0] wdata = 32'h0000_0000;
   logic [`NLANES-1:0] wstrb = 4'h0;
   logic [2:0] drv_en = 3'h0, drv_val = 3'h0;
   wire logic awready, wready, bvalid, arready, rvalid, irq;
   wire logic [1:0] bresp, rresp;
   wire logic [`DATA_W-1:0] rdata;
   wire logic [2:0] p_o, p_oe_n, p_i;
   int n_errors = 0;
   int check_count = 0;
   logic [31:0] rd;

   // 25 MHz clock
   always #20 aclk = ~aclk;

   triple_timer_pin_logic DUT
   (
      .aclk(aclk), .aresetn(aresetn),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .stop_req(stop_req), .wait_req(wait_req),
      .timer_pin_0_i(p_i[0]), .timer_pin_0_o(p_o[0]), .timer_pin_0_oe_n(p_oe_n[0]),
      .timer_pin_1_i(p_i[1]), .timer_pin_1_o(p_o[1]), .timer_pin_1_oe_n(p_oe_n[1]),
      .timer_pin_2_i(p_i[2]), .timer_pin_2_o(p_o[2]), .timer_pin_2_oe_n(p_oe_n[2]),
      .irq(irq)
   );

   pin_partner far_side
   (
      .aclk(aclk), .drv_en(drv_en), .drv_val(drv_val),
      .pin_o(p_o), .pin_oe_n(p_oe_n), .pin_i(p_i)
   );

   task automatic end_sim();
      if (n_errors == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_resp

   // one write; the bound on the wait stands in for a hang detector
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      int k;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (k = 0; k < 64; k++)
      begin
         @(posedge aclk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         if (bvalid && bready)
            break;
      end
      if (k == 64)
      begin
         chk("write timeout", 1, 0);
         end_sim();
      end
      chk_resp("write response", er, bresp);
      bready <= 1'b0;
   endtask : wr

   task automatic rdt(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
      int k;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (k = 0; k < 64; k++)
      begin
         @(posedge aclk);
         if (arvalid && arready)
            arvalid <= 1'b0;
         if (rvalid && rready)
            break;
      end
      if (k == 64)
      begin
         chk("read timeout", 1, 0);
         end_sim();
      end
      chk_resp("read response", er, rresp);
      d = rdata;
      rready <= 1'b0;
   endtask : rdt

   // control word as software would compose it
   function automatic logic [31:0] ctl(tmr_mode_e m, logic ext, logic gd, logic go, logic fn, logic en);
      return {24'h00_0000, fn, go, gd, ext, m, en};
   endfunction : ctl

   // pin direction expected from mode and function select
   function automatic logic exp_oe_n(tmr_mode_e m, logic fn, logic gd);
      return fn ? (m == MODE_EVENT || m == MODE_MEASURE) : !gd;
   endfunction : exp_oe_n

   // main sequence
   initial
   begin
      int i, m, c, n;
      logic g;
      logic [7:0] a;
      void'($urandom(32'hfb71_9570));
      repeat (16) @(posedge aclk);
      chk("pins during reset", 3'h7, p_oe_n);
      chk("irq during reset", 0, irq);
      aresetn <= 1'b1;
      for (i = 0; i < 3; i++)
      begin
         a = 8'(8'h10 * i);
         rdt(a, `RESP_OKAY, rd);
         chk("control reset", 0, rd[9:0]);
         rdt(a + 8'h04, `RESP_OKAY, rd);
         chk("compare reset", 32'h00ff_ffff, rd);
      end
      // unmapped places answer an error and no data
      for (int j = 0; j < 4; j++)
      begin
         a = (j == 0) ? 8'h38 : (j == 1) ? 8'h3c : (j == 2) ? 8'h40 : 8'hc0;
         rdt(a, `RESP_SLVERR, rd);
         chk("unmapped data", 0, rd);
         wr(a, $urandom, 4'hf, `RESP_SLVERR);
      end
      // every mode, timer function and gpio, on every pin
      for (i = 0; i < 3; i++)
         for (m = 0; m < 5; m++)
         begin
            g = 1'($urandom_range(1));
            a = 8'(8'h10 * i);
            wr(a, ctl(tmr_mode_e'(m), 0, g, 0, 1, 0), 4'hf, `RESP_OKAY);
            repeat (2) @(posedge aclk);
            chk("timer pin direction", exp_oe_n(tmr_mode_e'(m), 1, g), p_oe_n[i]);
            wr(a, ctl(tmr_mode_e'(m), 0, g, 0, 0, 0), 4'hf, `RESP_OKAY);
            repeat (2) @(posedge aclk);
            chk("gpio direction", exp_oe_n(tmr_mode_e'(m), 0, g), p_oe_n[i]);
         end
      // count to compare, masked then unmasked interrupt, then clear
      for (i = 0; i < 3; i++)
      begin
         c = (i == 0) ? 1 : 2 + $urandom_range(8);
         a = 8'(8'h10 * i);
         wr(8'h34, 0, 4'hf, `RESP_OKAY);
         wr(a + 8'h04, c, 4'hf, `RESP_OKAY);
         wr(a, ctl(MODE_TIMER, 0, 0, 0, 1, 1), 4'hf, `RESP_OKAY);
         repeat (c + 6) @(posedge aclk);
         chk("masked irq", 0, irq);
         chk("timer drives pin", 0, p_oe_n[i]);
         rdt(8'h30, `RESP_OKAY, rd);
         chk("done flag", 1, rd[i]);
         wr(8'h34, 1 << i, 4'hf, `RESP_OKAY);
         @(posedge aclk);
         chk("unmasked irq", 1, irq);
         wr(a, 0, 4'hf, `RESP_OKAY);
         wr(8'h30, 1 << i, 4'h1, `RESP_OKAY);
         @(posedge aclk);
         chk("cleared irq", 0, irq);
      end
      // external edges counted on each pin in turn
      for (i = 0; i < 3; i++)
      begin
         a = 8'(8'h10 * i);
         n = 1 + $urandom_range(5);
         drv_en[i] <= 1'b1;
         wr(a + 8'h04, 32'h0000_1000, 4'hf, `RESP_OKAY);
         wr(a, ctl(MODE_EVENT, 1, 0, 0, 1, 1), 4'hf, `RESP_OKAY);
         repeat (n)
         begin
            repeat (3) @(posedge aclk);
            drv_val[i] <= 1'b1;
            repeat (3) @(posedge aclk);
            drv_val[i] <= 1'b0;
         end
         repeat (6) @(posedge aclk);
         chk("counter pin is input", 1, p_oe_n[i]);
         rdt(a + 8'h08, `RESP_OKAY, rd);
         chk("event count", n, rd);
         rdt(a, `RESP_OKAY, rd);
         chk("pin level", 0, rd[10]);
         wr(a, 0, 4'hf, `RESP_OKAY);
         drv_en[i] <= 1'b0;
      end
      // pulse width measured on pin 0: one tick per high cycle
      n = 2 + $urandom_range(20);
      drv_en[0] <= 1'b1;
      wr(8'h00, ctl(MODE_MEASURE, 0, 0, 0, 1, 1), 4'hf, `RESP_OKAY);
      @(posedge aclk);
      drv_val[0] <= 1'b1;
      repeat (n) @(posedge aclk);
      drv_val[0] <= 1'b0;
      repeat (4) @(posedge aclk);
      chk("measure pin is input", 1, p_oe_n[0]);
      rdt(8'h08, `RESP_OKAY, rd);
      chk("measured width", n, rd);
      wr(8'h00, 0, 4'hf, `RESP_OKAY);
      drv_en[0] <= 1'b0;
      // gpio output through wait and stop
      g = 1'($urandom_range(1));
      wr(8'h20, ctl(MODE_TIMER, 0, 1, g, 0, 0), 4'hf, `RESP_OKAY);
      repeat (2) @(posedge aclk);
      for (i = 0; i < 16; i++)
      begin
         wait_req <= 1'($urandom_range(1));
         @(posedge aclk);
         chk("drive in wait", 0, p_oe_n[2]);
         chk("level in wait", g, p_o[2]);
      end
      wait_req <= 1'b0;
      stop_req <= 1'b1;
      repeat (2) @(posedge aclk);
      chk("stop tristate", 1, p_oe_n[2]);
      rdt(8'h20, `RESP_OKAY, rd);
      chk("direction kept", 1, rd[5]);
      stop_req <= 1'b0;
      repeat (2) @(posedge aclk);
      chk("drive after stop", 0, p_oe_n[2]);
      end_sim();
   end

   // whole-run limit
   initial
   begin
      repeat (100000) @(posedge aclk);
      chk("run timeout", 1, 0);
      end_sim();
   end
endmodule : triple_timer_pin_logic_tb
`default_nettype wire
